// ---- sft_defs.svh ----
/*
 * Constants for the serial flash tool-access block: pin frame layout,
 * array geometry and the minimum operation times.
 * Assumes the block clock runs at 200 MHz (5 ns period).
 */
`ifndef SFT_DEFS_SVH
`define SFT_DEFS_SVH

// ***********************************************
// frame layout
// ***********************************************
`define SFT_HDR_BITS     5'h18        // command byte plus 16 address bits
`define SFT_HDR_LAST     5'h17        // index of the last header bit
`define SFT_BYTE_LAST    5'h07        // index of the last bit of a byte
`define SFT_CMD_HI       7:3          // must be zero in a valid command byte
`define SFT_CMD_OP       2:0          // operation code field
`define SFT_CMD_FIELD    23:16        // command byte inside the header word
`define SFT_ADDR_FIELD   15:0         // address inside the header word

// ***********************************************
// array geometry
// ***********************************************
`define SFT_ADDR_W       16
`define SFT_SECT_MASK    16'hFF80     // 128-byte sector alignment
`define SFT_INFO_AW      8
`define SFT_INFO_BYTES   9'h100       // 256-byte information block
`define SFT_ERASED       8'hFF

// ***********************************************
// timing (minimum durations, ns)
// ***********************************************
`define SFT_CLK_NS       5
`define SFT_PROG_MIN_NS  20000        // byte program, 20 us (max 30 us)
`define SFT_CHIP_MIN_NS  32000000     // chip erase, 32 ms (max 70 ms)
`define SFT_SECT_MIN_NS  4000000      // sector erase, 4 ms (max 12 ms)

`endif

// ---- sft_pkg.sv ----
/*
 * Types shared by the serial flash tool-access block.
 * Assumes sft_defs.svh is on the include path.
 */
`include "sft_defs.svh"

package sft_pkg;

   // operation codes carried in the command byte
   typedef enum logic [2:0] {
      OP_NONE   = 3'h0,
      OP_READ   = 3'h1,
      OP_PROG   = 3'h2,
      OP_SECT   = 3'h3,
      OP_CHIP   = 3'h4,
      OP_IREAD  = 3'h5,
      OP_IWRITE = 3'h6,
      OP_IERASE = 3'h7
   } sft_op_t;

   // one flash operation as it travels to the main array
   typedef struct packed {
      sft_op_t                  op;
      logic [`SFT_ADDR_W-1:0]   addr;
      logic [7:0]               data;
   } sft_cmd_t;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_CMD    = 3'h1,
      ST_WDATA  = 3'h2,
      ST_EXEC   = 3'h3,
      ST_RDWAIT = 3'h4,
      ST_RDATA  = 3'h5,
      ST_BUSY   = 3'h6
   } sft_state_t;

endpackage

// ---- sft_info_mem.sv ----
/*
 * Information block storage: single port, registered read data.
 * Assumes one write or one read per cycle from the access block.
 */
`timescale 1ns/1ps
`default_nettype none

module sft_info_mem #(
   parameter int AW = 8,
   parameter int DW = 8
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] mem_reg [0:(1<<AW)-1];
   logic [DW-1:0] rdata_reg;
   logic [DW-1:0] rdata_next;

   // read port sees the old word on a same-address write
   always_comb begin
      rdata_next = mem_reg[addr];
   end

   always_ff @(posedge clk) begin
      if (we) begin
         mem_reg[addr] <= wdata;
      end
      if (rst) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign rdata = rdata_reg;
endmodule

`default_nettype wire

// ---- sft_tool_access.sv ----
/*
 * Tool-mode access logic for the multi_time_flash and its information block.
 * Assumes pins arrive unsynchronised, the main array sits behind fl_* and
 * answers reads with fl_rvalid, and vpp_high comes from an 11 V detector.
 */
// Summary of operation
// - serial_data_line is driven by us only while read data is shifted out.
// - the serial clock is only sampled; every transfer edge comes from the programmer.
// - tool mode is entered only while the programming voltage is detected.
// - a byte program holds the block busy for the program time before new work.
// - chip erase clears the whole array and holds the block busy its full time.
// - sector erase clears one 128-byte block and holds the block busy its time.
// - chip erase is accepted only in tool mode and refused in user mode.
// - a 256-byte information block is addressed apart from the main array.
// - main array operations never reach the information block.
// - dedicated operations erase, write and read the information block only.
// - all information block access is blocked in user mode.
`timescale 1ns/1ps
`default_nettype none
`include "sft_defs.svh"

module sft_tool_access #(
   parameter int unsigned CHIP_CYC = (`SFT_CHIP_MIN_NS + `SFT_CLK_NS - 1) / `SFT_CLK_NS,
   parameter int unsigned SECT_CYC = (`SFT_SECT_MIN_NS + `SFT_CLK_NS - 1) / `SFT_CLK_NS
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             sclk_pin,
   input  wire logic             serial_data_line_in,
   output logic                  serial_data_line_out,
   output logic                  serial_data_line_oe_n,
   input  wire logic             vpp_high,
   input  wire logic             user_req,
   input  wire sft_pkg::sft_cmd_t user_cmd,
   output logic                  user_reject,
   output logic                  fl_valid,
   input  wire logic             fl_ready,
   output sft_pkg::sft_cmd_t     fl_cmd,
   input  wire logic             fl_rvalid,
   input  wire logic [7:0]       fl_rdata,
   output logic                  tool_mode,
   output logic                  busy
);
   import sft_pkg::*;

   localparam int unsigned PROG_CYC = (`SFT_PROG_MIN_NS + `SFT_CLK_NS - 1) / `SFT_CLK_NS;

   // ***********************************************
   // pin synchronisers
   // ***********************************************
   logic sclk_s1_reg, sclk_s2_reg, sclk_d_reg;
   logic dat_s1_reg,  dat_s2_reg;
   logic vpp_s1_reg,  vpp_s2_reg;
   logic sclk_rise, sclk_fall;

   // two flops per pin; edges are found only on the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         sclk_s1_reg <= 1'b0;
         sclk_s2_reg <= 1'b0;
         sclk_d_reg  <= 1'b0;
         dat_s1_reg  <= 1'b0;
         dat_s2_reg  <= 1'b0;
         vpp_s1_reg  <= 1'b0;
         vpp_s2_reg  <= 1'b0;
      end else begin
         sclk_s1_reg <= sclk_pin;
         sclk_s2_reg <= sclk_s1_reg;
         sclk_d_reg  <= sclk_s2_reg;
         dat_s1_reg  <= serial_data_line_in;
         dat_s2_reg  <= dat_s1_reg;
         vpp_s1_reg  <= vpp_high;
         vpp_s2_reg  <= vpp_s1_reg;
      end
   end

   assign sclk_rise = sclk_s2_reg & ~sclk_d_reg;
   assign sclk_fall = ~sclk_s2_reg & sclk_d_reg;
   assign tool_mode = vpp_s2_reg;

   // ***********************************************
   // state
   // ***********************************************
   sft_state_t    st_reg,    st_next;
   logic [4:0]    bit_reg,   bit_next;
   logic [23:0]   sh_reg,    sh_next;
   sft_cmd_t      cmd_reg,   cmd_next;
   logic [7:0]    rsh_reg,   rsh_next;
   logic [31:0]   tmr_reg,   tmr_next;
   logic [8:0]    sweep_reg, sweep_next;
   logic          rej_reg,   rej_next;
   sft_cmd_t      b0_reg, b0_next, b1_reg, b1_next;
   logic [1:0]    bcnt_reg,  bcnt_next;

   logic [23:0]   hdr_word;
   logic [7:0]    hdr_cmd;
   logic [7:0]    info_rdata, info_wdata;
   logic [7:0]    info_addr;
   logic          info_we, push, pop, push_ready, user_ok;
   sft_cmd_t      push_cmd;

   assign hdr_word   = {sh_reg[22:0], dat_s2_reg};
   assign hdr_cmd    = hdr_word[`SFT_CMD_FIELD];
   assign push_ready = (bcnt_reg != 2'h2);
   assign pop        = fl_valid & fl_ready;
   assign user_ok    = user_req & ~tool_mode & (st_reg == ST_IDLE) &
                       (user_cmd.op inside {OP_READ, OP_PROG, OP_SECT});

   // minimum-time load per operation; max time is met by ending at the min
   function automatic logic [31:0] hold_cycles(input sft_op_t op);
      case (op)
         OP_PROG, OP_IWRITE: hold_cycles = 32'(PROG_CYC - 1);
         OP_SECT, OP_IERASE: hold_cycles = 32'(SECT_CYC - 1);
         OP_CHIP:            hold_cycles = 32'(CHIP_CYC - 1);
         default:            hold_cycles = 32'h0;
      endcase
   endfunction

   // serial frame decoder, operation sequencer and busy timer
   always_comb begin
      st_next    = st_reg;
      bit_next   = bit_reg;
      sh_next    = sh_reg;
      cmd_next   = cmd_reg;
      rsh_next   = rsh_reg;
      tmr_next   = tmr_reg;
      sweep_next = sweep_reg;
      rej_next   = user_req & ~user_ok;
      info_we    = 1'b0;
      info_addr  = cmd_reg.addr[`SFT_INFO_AW-1:0];
      info_wdata = cmd_reg.data;
      push       = 1'b0;
      push_cmd   = cmd_reg;
      if (cmd_reg.op == OP_SECT) begin
         push_cmd.addr = cmd_reg.addr & `SFT_SECT_MASK;
      end
      case (st_reg)
         ST_IDLE: begin
            bit_next = 5'h0;
            if (tool_mode && sclk_rise) begin
               sh_next  = hdr_word;
               bit_next = 5'h1;
               st_next  = ST_CMD;
            end else if (user_ok) begin
               cmd_next = user_cmd;
               st_next  = ST_EXEC;
            end
         end
         ST_CMD: begin
            if (!tool_mode) begin
               st_next = ST_IDLE;
            end else if (sclk_rise) begin
               sh_next  = hdr_word;
               bit_next = bit_reg + 5'h1;
               if (bit_reg == `SFT_HDR_LAST) begin
                  bit_next      = 5'h0;
                  cmd_next.op   = sft_op_t'(hdr_cmd[`SFT_CMD_OP]);
                  cmd_next.addr = hdr_word[`SFT_ADDR_FIELD];
                  if (hdr_cmd[`SFT_CMD_HI] != 5'h0 || hdr_cmd[`SFT_CMD_OP] == OP_NONE) begin
                     st_next = ST_IDLE;                  // unknown command dropped
                  end else if (hdr_cmd[`SFT_CMD_OP] == OP_PROG ||
                               hdr_cmd[`SFT_CMD_OP] == OP_IWRITE) begin
                     st_next = ST_WDATA;
                  end else begin
                     st_next = ST_EXEC;
                  end
               end
            end
         end
         ST_WDATA: begin
            if (!tool_mode) begin
               st_next = ST_IDLE;
            end else if (sclk_rise) begin
               sh_next  = hdr_word;
               bit_next = bit_reg + 5'h1;
               if (bit_reg == `SFT_BYTE_LAST) begin
                  cmd_next.data = hdr_word[`SFT_BYTE_LAST:0];
                  st_next       = ST_EXEC;
               end
            end
         end
         ST_EXEC: begin
            bit_next = 5'h0;
            tmr_next = hold_cycles(cmd_reg.op);
            case (cmd_reg.op)
               OP_IREAD, OP_IWRITE, OP_IERASE: begin
                  if (!tool_mode) begin
                     st_next = ST_IDLE;
                  end else if (cmd_reg.op == OP_IREAD) begin
                     st_next = ST_RDWAIT;
                  end else begin
                     info_we    = (cmd_reg.op == OP_IWRITE);
                     sweep_next = 9'h0;
                     st_next    = ST_BUSY;
                  end
               end
               OP_CHIP: begin
                  if (!tool_mode) begin
                     st_next = ST_IDLE;
                  end else if (push_ready) begin
                     push    = 1'b1;
                     st_next = ST_BUSY;
                  end
               end
               default: begin
                  if (push_ready) begin
                     push    = 1'b1;
                     st_next = (cmd_reg.op == OP_READ) ?
                               (tool_mode ? ST_RDWAIT : ST_IDLE) : ST_BUSY;
                  end
               end
            endcase
         end
         ST_RDWAIT: begin
            if (!tool_mode) begin
               st_next = ST_IDLE;
            end else if (cmd_reg.op == OP_IREAD) begin
               rsh_next = info_rdata;
               st_next  = ST_RDATA;
            end else if (fl_rvalid) begin
               rsh_next = fl_rdata;
               st_next  = ST_RDATA;
            end
         end
         ST_RDATA: begin
            if (!tool_mode) begin
               st_next = ST_IDLE;
            end else if (sclk_rise) begin
               bit_next = bit_reg + 5'h1;
               if (bit_reg == `SFT_BYTE_LAST) begin
                  st_next = ST_IDLE;
               end
            end else if (sclk_fall && bit_reg != 5'h0) begin
               rsh_next = {rsh_reg[6:0], 1'b0};
            end
         end
         ST_BUSY: begin
            tmr_next = tmr_reg - 32'h1;
            if (cmd_reg.op == OP_IERASE && sweep_reg != `SFT_INFO_BYTES) begin
               info_we    = tool_mode;
               info_addr  = sweep_reg[`SFT_INFO_AW-1:0];
               info_wdata = `SFT_ERASED;
               sweep_next = sweep_reg + 9'h1;
            end
            if (tmr_reg == 32'h0) begin
               st_next = ST_IDLE;
            end
         end
         default: st_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg    <= ST_IDLE;
         bit_reg   <= 5'h0;
         sh_reg    <= 24'h0;
         cmd_reg   <= '0;
         rsh_reg   <= 8'h0;
         tmr_reg   <= 32'h0;
         sweep_reg <= 9'h0;
         rej_reg   <= 1'b0;
      end else begin
         st_reg    <= st_next;
         bit_reg   <= bit_next;
         sh_reg    <= sh_next;
         cmd_reg   <= cmd_next;
         rsh_reg   <= rsh_next;
         tmr_reg   <= tmr_next;
         sweep_reg <= sweep_next;
         rej_reg   <= rej_next;
      end
   end

   // ***********************************************
   // two-entry command buffer toward the main array
   // ***********************************************
   // a stalled array holds the sequencer in ST_EXEC, so no command is lost
   always_comb begin
      b0_next   = b0_reg;
      b1_next   = b1_reg;
      bcnt_next = bcnt_reg;
      case ({push, pop})
         2'b10: begin
            if (bcnt_reg == 2'h0) b0_next = push_cmd;
            else                  b1_next = push_cmd;
            bcnt_next = bcnt_reg + 2'h1;
         end
         2'b01: begin
            b0_next   = b1_reg;
            bcnt_next = bcnt_reg - 2'h1;
         end
         2'b11: begin
            if (bcnt_reg == 2'h1) begin
               b0_next = push_cmd;
            end else begin
               b0_next = b1_reg;
               b1_next = push_cmd;
            end
         end
         default: bcnt_next = bcnt_reg;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         b0_reg   <= '0;
         b1_reg   <= '0;
         bcnt_reg <= 2'h0;
      end else begin
         b0_reg   <= b0_next;
         b1_reg   <= b1_next;
         bcnt_reg <= bcnt_next;
      end
   end

   sft_info_mem #(.AW(`SFT_INFO_AW), .DW(8)) u_info (
      .clk   (clk),
      .rst   (rst),
      .we    (info_we),
      .addr  (info_addr),
      .wdata (info_wdata),
      .rdata (info_rdata)
   );

   assign fl_valid              = (bcnt_reg != 2'h0);
   assign fl_cmd                = b0_reg;
   assign serial_data_line_out  = rsh_reg[7];
   assign serial_data_line_oe_n = ~(st_reg == ST_RDATA);
   assign user_reject           = rej_reg;
   assign busy                  = (st_reg != ST_IDLE);

   // ***********************************************
   // checks
   // ***********************************************
   logic [31:0] elapsed_reg;
   always_ff @(posedge clk) begin
      if (rst || st_reg != ST_BUSY) elapsed_reg <= 32'h0;
      else                          elapsed_reg <= elapsed_reg + 32'h1;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   a_line_drive: assert property (
      !serial_data_line_oe_n |-> st_reg == ST_RDATA && $past(tool_mode))
      else $error("data line driven outside a read");
   a_frame_edge: assert property (
      st_reg == ST_CMD && tool_mode && !sclk_rise |=> $stable(sh_reg))
      else $error("frame shifted without clock edge");
   a_tool_gate: assert property (!tool_mode |-> ##1 st_reg != ST_CMD || tool_mode)
      else $error("frame decoded outside tool mode");
   a_prog_hold: assert property (
      st_reg == ST_BUSY && tmr_reg == 32'h0 && cmd_reg.op == OP_PROG |->
      elapsed_reg == PROG_CYC - 1)
      else $error("program time wrong");
   a_chip_hold: assert property (
      st_reg == ST_BUSY && tmr_reg == 32'h0 && cmd_reg.op == OP_CHIP |->
      elapsed_reg == CHIP_CYC - 1)
      else $error("chip erase time wrong");
   a_sect_hold: assert property (
      st_reg == ST_BUSY && tmr_reg == 32'h0 && cmd_reg.op == OP_SECT |->
      elapsed_reg == SECT_CYC - 1)
      else $error("sector erase time wrong");
   // busy may only end when the timer has run out
   a_busy_hold: assert property (
      st_reg == ST_BUSY && tmr_reg != 32'h0 |=> st_reg == ST_BUSY)
      else $error("busy ended before its time");
   a_chip_user: assert property (user_req && user_cmd.op == OP_CHIP |=> user_reject)
      else $error("user chip erase not refused");
   a_info_user: assert property (!tool_mode |-> !info_we)
      else $error("information block touched in user mode");
   a_main_isol: assert property (info_we |-> cmd_reg.op inside {OP_IWRITE, OP_IERASE})
      else $error("main operation wrote information block");
   a_info_path: assert property (
      fl_valid |-> !(fl_cmd.op inside {OP_IREAD, OP_IWRITE, OP_IERASE}))
      else $error("information operation sent to main array");
   a_info_sweep: assert property (
      st_reg == ST_BUSY && tmr_reg == 32'h0 && cmd_reg.op == OP_IERASE && tool_mode |->
      sweep_reg == `SFT_INFO_BYTES)
      else $error("information erase incomplete");
endmodule

`default_nettype wire

// ---- sft_prog_model.sv ----
/*
 * Programmer model for the two-wire tool link: clock and data line.
 * Assumes the block under test samples both pins with its own clock.
 */
`timescale 1ns/1ps
`default_nettype none

module sft_prog_model (
   input  wire logic dut_dat,
   input  wire logic dut_oe_n,
   output logic      sclk,
   output logic      line
);
   // ***********************************************
   // link driver
   // ***********************************************
   logic drv_bit;
   logic drv_on;

   // a released line shows the inverse of the last bit, never a stale copy
   assign line = !dut_oe_n ? dut_dat : (drv_on ? drv_bit : ~drv_bit);

   // clock stands low between frames
   initial begin
      sclk = 1'b0;
      drv_bit = 1'b0;
      drv_on = 1'b0;
   end

   // data changes at the falling edge, held half a period either side
   task automatic bit_out(input logic v);
      drv_bit = v;
      drv_on = 1'b1;
      #32;
      sclk = 1'b1;
      #32;
      sclk = 1'b0;
   endtask

   // one whole frame, msb first; reads return the byte and whether it came
   task automatic frame(input logic [7:0] cmd, input logic [15:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output bit ok);
      int k;
      logic [23:0] hdr;
      rd = 'x;
      hdr = {cmd, a};
      ok = 1'b0;
      for (int i = 23; i >= 0; i--) bit_out(hdr[i]);
      if (cmd[2:0] == 3'h2 || cmd[2:0] == 3'h6) begin
         for (int i = 7; i >= 0; i--) bit_out(d[i]);
      end
      drv_on = 1'b0;
      if (cmd[2:0] == 3'h1 || cmd[2:0] == 3'h5) begin
         for (k = 0; k < 400 && dut_oe_n !== 1'b0; k++) #5;
         ok = (dut_oe_n === 1'b0);
         if (ok) begin
            for (int i = 7; i >= 0; i--) begin
               #32;
               rd[i] = line;
               sclk = 1'b1;
               #32;
               sclk = 1'b0;
            end
         end
      end
   endtask
endmodule

`default_nettype wire

// ---- sft_tool_access_tb.sv ----
/*
 * Self-checking bench: user port, tool frames and an array stub.
 * Assumes the programmer model owns the link pins in its own time base.
 */
`timescale 1ns/1ps
`default_nettype none

module sft_tool_access_tb;
   import sft_pkg::*;
   // ***********************************************
   // setup
   // ***********************************************
   localparam int SECT = 300;
   localparam int CHIP = 400;
   localparam int PROG = 4000;
   localparam logic [31:0] ALL = 32'h07FFFFFF;
   localparam logic [31:0] NOD = 32'h07FFFF00;
   logic       clk, rst, vpp, ureq, rdy, rv, sclk, line, dout, oe_n, rej, flv, tm, busy;
   logic [7:0] rd_d, b;
   sft_cmd_t   ucmd, fcmd, c;
   sft_cmd_t   got[$];
   int         mismatches, total_checks, rejs, n;
   bit         ok;

   sft_tool_access #(.CHIP_CYC(CHIP), .SECT_CYC(SECT)) u_dut (
      .clk(clk), .rst(rst), .sclk_pin(sclk), .serial_data_line_in(line),
      .serial_data_line_out(dout), .serial_data_line_oe_n(oe_n), .vpp_high(vpp),
      .user_req(ureq), .user_cmd(ucmd), .user_reject(rej), .fl_valid(flv), .fl_ready(rdy),
      .fl_cmd(fcmd), .fl_rvalid(rv), .fl_rdata(rd_d), .tool_mode(tm), .busy(busy));
   sft_prog_model u_prog (.dut_dat(dout), .dut_oe_n(oe_n), .sclk(sclk), .line(line));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // array stub: logs taken commands, answers reads one cycle later
   always @(posedge clk) begin
      rv <= 1'b0;
      if (rej === 1'b1) rejs++;
      if (flv === 1'b1 && rdy === 1'b1) begin
         got.push_back(fcmd);
         rv <= (fcmd.op === OP_READ);
         rd_d <= fcmd.addr[7:0] ^ 8'h5A;
      end
   end

   // ***********************************************
   // helpers
   // ***********************************************
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk_dur(input int g, input int lo, input int hi);
      total_checks++;
      if (g < lo || g > hi) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, lo);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic user(input sft_op_t op, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      ureq <= 1'b1;
      ucmd <= '{op, a, d};
      @(posedge clk);
      ureq <= 1'b0;
      tick(3);
   endtask

   // cycles busy stays high; lim keeps a stuck block from hanging us
   task automatic dur(output int k, input int lim);
      k = 0;
      for (int i = 0; i < 20 && busy !== 1'b1; i++) tick(1);
      while (busy === 1'b1 && k < lim) begin
         tick(1);
         k++;
      end
   endtask

   task automatic pop(input logic [31:0] e, input logic [31:0] m);
      c = (got.size() > 0) ? got.pop_front() : 'x;
      chk(c & m, e & m);
   endtask

   // ***********************************************
   // scenarios
   // ***********************************************
   task automatic t_user();
      user(OP_PROG, 16'h1234, 8'hA5);
      dur(n, PROG + 50);
      chk_dur(n, PROG - 10, PROG + 10);
      pop({5'h0, OP_PROG, 16'h1234, 8'hA5}, ALL);
      user(OP_SECT, 16'h12FF, 8'h00);
      dur(n, SECT + 50);
      chk_dur(n, SECT - 10, SECT + 10);
      pop({5'h0, OP_SECT, 16'h1280, 8'h00}, NOD);
      user(OP_READ, 16'h0042, 8'h00);
      pop({5'h0, OP_READ, 16'h0042, 8'h00}, NOD);
      for (int o = 4; o < 8; o++) user(sft_op_t'(o), 16'h0010, 8'h00);
      user(OP_NONE, 16'h0000, 8'h00);
      chk(rejs, 5);
      chk(got.size(), 0);
   endtask

   // receiver stalls: two entries held, third waits, none lost
   task automatic t_buf();
      @(posedge clk);
      rdy <= 1'b0;
      for (int i = 1; i < 4; i++) begin
         user(OP_SECT, 16'(i * 256), 8'h00);
         dur(n, SECT + 100);
      end
      chk(busy, 1'b1);
      chk(flv, 1'b1);
      chk(fcmd.addr, 16'h0100);
      @(posedge clk);
      rdy <= 1'b1;
      dur(n, SECT + 100);
      for (int i = 1; i < 4; i++) pop({5'h0, OP_SECT, 16'(i * 256), 8'h00}, NOD);
   endtask

   task automatic t_tool();
      u_prog.frame(8'h05, 16'h0010, 8'h00, b, ok);
      chk(ok, 1'b0);
      @(posedge clk);
      vpp <= 1'b1;
      tick(4);
      chk(tm, 1'b1);
      user(OP_PROG, 16'h0000, 8'h00);
      chk(rejs, 6);
      u_prog.frame(8'h06, 16'hFF10, 8'h3C, b, ok);
      chk(oe_n, 1'b1);
      dur(n, PROG + 50);
      chk_dur(n, PROG - 20, PROG + 10);
      u_prog.frame(8'h04, 16'h0000, 8'h00, b, ok);
      dur(n, CHIP + 50);
      chk_dur(n, CHIP - 20, CHIP + 10);
      pop({5'h0, OP_CHIP, 16'h0000, 8'h00}, 32'h07000000);
      u_prog.frame(8'h01, 16'h0010, 8'h00, b, ok);
      chk(b, 8'h4A);
      pop({5'h0, OP_READ, 16'h0010, 8'h00}, NOD);
      u_prog.frame(8'h05, 16'h0010, 8'h00, b, ok);
      chk(b, 8'h3C);
      u_prog.frame(8'h08, 16'h0010, 8'h00, b, ok);
      tick(10);
      chk(busy, 1'b0);
      u_prog.frame(8'h07, 16'h0000, 8'h00, b, ok);
      dur(n, SECT + 400);
      chk_dur(n, SECT - 20, SECT + 20);
      u_prog.frame(8'h05, 16'h0010, 8'h00, b, ok);
      chk(b, 8'hFF);
      u_prog.frame(8'h02, 16'h0321, 8'h96, b, ok);
      dur(n, PROG + 50);
      pop({5'h0, OP_PROG, 16'h0321, 8'h96}, ALL);
      chk(got.size(), 0);
   endtask

   task automatic summarize();
      if (mismatches == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ***********************************************
   // main sequence and watchdog
   // ***********************************************
   initial begin
      rst = 1'b1;
      vpp = 1'b0;
      ureq = 1'b0;
      rdy = 1'b1;
      ucmd = '0;
      mismatches = 0;
      total_checks = 0;
      rejs = 0;
      tick(12);
      chk(oe_n, 1'b1);
      chk(flv, 1'b0);
      chk(busy, 1'b0);
      chk(tm, 1'b0);
      @(posedge clk);
      rst <= 1'b0;
      tick(2);
      t_user();
      t_buf();
      t_tool();
      summarize();
   end

   // whole run is near 100 us; a hang is cut at 80k cycles
   initial begin
      #400000;
      mismatches++;
      summarize();
   end
endmodule

`default_nettype wire
